/* File: acdf_chan_check.sv */
// Purpose: range, wire break and limit evaluation for one channel value
// Assumes: raw and smoothed values in mV or uA
// Notes: combinational only
`timescale 1ns/1ps
module acdf_chan_check
    import acdf_pkg::*;
(
    // request and result
    acdf_check_if.chk chk
);
    always_comb
    begin
        chk.wire_break = 1'b0;
        chk.overflow = 1'b0;
        chk.underflow = 1'b0;
        unique case (chk.range)
            RANGE_U_1_5:
            begin
                chk.wire_break = chk.raw <= WB_U_MV;
                chk.overflow = chk.value >= OVF_U15_MV;
                chk.underflow = chk.value <= WB_U_MV;
            end
            RANGE_U_PM10:
            begin
                chk.overflow = chk.value >= OVF_U10_MV;
                chk.underflow = chk.value <= UNF_U10_MV;
            end
            RANGE_I_4_20:
            begin
                chk.wire_break = chk.raw <= WB_I_UA;
                chk.overflow = chk.value >= OVF_I420_UA;
                chk.underflow = chk.value <= WB_I_UA;
            end
            RANGE_I_0_20:
            begin
                chk.overflow = chk.value >= OVF_I020_UA;
                chk.underflow = chk.value <= UNF_I020_UA;
            end
            default:
            begin
                chk.wire_break = 1'b0;
            end
        endcase
        chk.above_hi = chk.value > chk.hi_lim;
        chk.below_lo = chk.value < chk.lo_lim;
    end
endmodule

/* File: acdf_check_if.sv */
// Purpose: carries one channel's values to the range/limit checker and back
// Assumes: checker is purely combinational
// Notes: req side is the sequencer, chk side is the checker
`timescale 1ns/1ps
interface acdf_check_if;
    import acdf_pkg::*;
    acdf_range_t range;
    logic signed [DW-1:0] raw;
    logic signed [DW-1:0] value;
    logic signed [DW-1:0] hi_lim;
    logic signed [DW-1:0] lo_lim;
    logic wire_break;
    logic overflow;
    logic underflow;
    logic above_hi;
    logic below_lo;
    modport req (output range, raw, value, hi_lim, lo_lim,
        input wire_break, overflow, underflow, above_hi, below_lo);
    modport chk (input range, raw, value, hi_lim, lo_lim,
        output wire_break, overflow, underflow, above_hi, below_lo);
endinterface

/* File: acdf_conv_model.sv */
// Purpose: converter stand-in feeding one sample per integration window
// Assumes: gate and channel come from the block under test
// Notes: outside a window the line shows the inverse of the last value
`timescale 1ns/1ps
module acdf_conv_model
    import acdf_pkg::*;
(
    // clock and converter link
    input wire logic clock_i,
    input wire logic gate_i,
    input wire logic [acdf_pkg::CW-1:0] chan_i,
    input wire logic [acdf_pkg::NCH-1:0][acdf_pkg::DW-1:0] level_i,
    output logic [acdf_pkg::DW-1:0] sample_o
);
    logic [DW-1:0] last_ff = '0;
    always_ff @(posedge clock_i)
    begin
        if (gate_i)
        begin
            last_ff <= level_i[chan_i];
        end
    end
    assign sample_o = gate_i ? level_i[chan_i] : ~last_ff;
endmodule

/* File: acdf_filt_mem.sv */
// Purpose: per-channel smoothing accumulator store
// Assumes: one write and one read per clock
// Notes: read data comes from a register, one cycle after the address
`timescale 1ns/1ps
module acdf_filt_mem
    import acdf_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_b_i,
    // write port
    input wire logic wr_en_i,
    input wire logic [CW-1:0] wr_addr_i,
    input wire logic [AW-1:0] wr_data_i,
    // read port
    input wire logic [CW-1:0] rd_addr_i,
    output logic [AW-1:0] rd_data_o
);
    typedef struct packed {
        logic [NCH-1:0][AW-1:0] mem;
        logic [AW-1:0] rd;
    } acdf_mem_t;

    acdf_mem_t s_ff;
    acdf_mem_t nxt_s;

    always_comb
    begin
        nxt_s = s_ff;
        nxt_s.rd = s_ff.mem[rd_addr_i];
        if (wr_en_i)
        begin
            nxt_s.mem[wr_addr_i] = wr_data_i;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            s_ff <= '0;
        end
        else
        begin
            s_ff <= nxt_s;
        end
    end

    assign rd_data_o = s_ff.rd;
endmodule

/* File: acdf_pkg.sv */
// Purpose: shared constants and types for the analog channel diag/filter block
// Assumes: 50 MHz module clock; samples are signed mV (voltage) or uA (current)
// Notes: timing counts above 4096 cycles are overridable at the top level
package acdf_pkg;

    localparam int NCH = 4;
    localparam int DW = 16;
    localparam int FRAC = 8;
    localparam int AW = DW + FRAC;
    localparam int CW = 2;

    // module clock and integration timing
    localparam int CLK_MHZ = 50;
    localparam int INTEG_10HZ_US = 100000;
    localparam int INTEG_50HZ_US = 20000;
    localparam int INTEG_60HZ_US = 16667;
    localparam int INTEG_10HZ_CYC = INTEG_10HZ_US * CLK_MHZ;
    localparam int INTEG_50HZ_CYC = INTEG_50HZ_US * CLK_MHZ;
    localparam int INTEG_60HZ_CYC = INTEG_60HZ_US * CLK_MHZ;
    localparam int FAST_SH = 2;
    localparam int CNT_W = 23;

    // smoothing depth as a shift: 1, 4, 16, 32 module cycles
    localparam int SMOOTH_SH_NONE = 0;
    localparam int SMOOTH_SH_WEAK = 2;
    localparam int SMOOTH_SH_MEDIUM = 4;
    localparam int SMOOTH_SH_STRONG = 5;

    // wire break / undershoot and range limits (mV or uA)
    localparam logic signed [DW-1:0] WB_U_MV = 16'sd296;
    localparam logic signed [DW-1:0] WB_I_UA = 16'sd1185;
    localparam logic signed [DW-1:0] OVF_U15_MV = 16'sd5704;
    localparam logic signed [DW-1:0] OVF_U10_MV = 16'sd11759;
    localparam logic signed [DW-1:0] UNF_U10_MV = -16'sd11759;
    localparam logic signed [DW-1:0] OVF_I420_UA = 16'sd22815;
    localparam logic signed [DW-1:0] OVF_I020_UA = 16'sd23518;
    localparam logic signed [DW-1:0] UNF_I020_UA = -16'sd3518;

    // substitute codes
    localparam logic [DW-1:0] VAL_WB_DIAG = 16'h7FFF;
    localparam logic [DW-1:0] VAL_WB_NODIAG = 16'h8000;

    typedef enum logic [2:0] {
        RANGE_OFF, RANGE_U_1_5, RANGE_U_PM10, RANGE_I_4_20, RANGE_I_0_20
    } acdf_range_t;

    typedef enum logic [1:0] {
        SMOOTH_NONE, SMOOTH_WEAK, SMOOTH_MEDIUM, SMOOTH_STRONG
    } acdf_smooth_t;

    typedef enum logic [1:0] {
        FREQ_10HZ, FREQ_50HZ, FREQ_60HZ
    } acdf_freq_t;

endpackage

/* File: acdf_top.sv */
// Purpose: channel sequencer, smoothing and diagnostics for a 4-channel analog input
// Assumes: converter sample_i is valid in the last cycle that conv_gate_o is high
// Notes: one module cycle visits every enabled channel in order 0..3
`timescale 1ns/1ps
module acdf_top
    import acdf_pkg::*;
#(
    parameter int P_INTEG_10HZ_CYC = acdf_pkg::INTEG_10HZ_CYC,
    parameter int P_INTEG_50HZ_CYC = acdf_pkg::INTEG_50HZ_CYC,
    parameter int P_INTEG_60HZ_CYC = acdf_pkg::INTEG_60HZ_CYC
)
(
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_b_i,
    // module configuration
    input wire logic group_diag_en_i,
    input wire logic enc_diag_en_i,
    input wire logic limit_irq_en_i,
    input wire logic fast_mode_i,
    input wire acdf_pkg::acdf_freq_t freq_sel_i,
    // channel configuration
    input wire acdf_pkg::acdf_range_t [acdf_pkg::NCH-1:0] range_i,
    input wire acdf_pkg::acdf_smooth_t [acdf_pkg::NCH-1:0] smooth_i,
    input wire logic [acdf_pkg::NCH-1:0] wb_diag_en_i,
    input wire logic [acdf_pkg::NCH-1:0] ovf_diag_en_i,
    input wire logic [acdf_pkg::NCH-1:0] sc_in_diag_en_i,
    input wire logic [acdf_pkg::NCH-1:0] sc_out_diag_en_i,
    input wire logic [acdf_pkg::NCH-1:0][acdf_pkg::DW-1:0] hi_limit_i,
    input wire logic [acdf_pkg::NCH-1:0][acdf_pkg::DW-1:0] lo_limit_i,
    // converter and fault detectors
    input wire logic [acdf_pkg::DW-1:0] sample_i,
    input wire logic [acdf_pkg::NCH-1:0] in_short_i,
    input wire logic [acdf_pkg::NCH-1:0] out_short_p_i,
    input wire logic [acdf_pkg::NCH-1:0] out_short_m_i,
    input wire logic enc_short_i,
    output logic conv_gate_o,
    output logic [acdf_pkg::CW-1:0] conv_chan_o,
    // results toward the station
    output logic [acdf_pkg::NCH-1:0][acdf_pkg::DW-1:0] value_o,
    output logic value_valid_o,
    output logic [acdf_pkg::CW-1:0] value_chan_o,
    output logic cycle_done_o,
    output logic [acdf_pkg::NCH-1:0] diag_wb_o,
    output logic [acdf_pkg::NCH-1:0] diag_ovf_o,
    output logic [acdf_pkg::NCH-1:0] diag_unf_o,
    output logic [acdf_pkg::NCH-1:0] diag_sc_in_o,
    output logic [acdf_pkg::NCH-1:0] diag_sc_out_o,
    output logic diag_enc_o,
    output logic limit_irq_o,
    output logic [acdf_pkg::CW-1:0] limit_chan_o,
    output logic limit_hi_o
);
    typedef enum logic [1:0] {ST_SCAN, ST_INTEG, ST_UPD} acdf_state_t;

    typedef struct packed {
        acdf_state_t st;
        logic [CW-1:0] chan;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] gate_len;
        acdf_freq_t cap_freq;
        logic cap_fast;
        logic gate;
        logic [DW-1:0] sample;
        logic [NCH-1:0][DW-1:0] value;
        logic valid;
        logic [CW-1:0] val_chan;
        logic done;
        logic [NCH-1:0] wb;
        logic [NCH-1:0] ovf;
        logic [NCH-1:0] unf;
        logic [NCH-1:0] sc_in;
        logic [NCH-1:0] sc_out;
        logic enc;
        logic [NCH-1:0] hi_above;
        logic [NCH-1:0] lo_below;
        logic irq;
        logic [CW-1:0] irq_chan;
        logic irq_hi;
    } acdf_top_t;

    acdf_top_t s_ff;
    acdf_top_t nxt_s;
    logic [AW-1:0] rd_acc;
    logic signed [AW:0] diff;
    logic signed [AW:0] step;
    logic [AW-1:0] acc_new;
    logic [DW-1:0] smooth_val;
    acdf_check_if chk_if ();

    function automatic logic [CNT_W-1:0] integ_cycles(acdf_freq_t f, logic fast);
        logic [CNT_W-1:0] c;
        unique case (f)
            FREQ_10HZ: c = CNT_W'(P_INTEG_10HZ_CYC);
            FREQ_50HZ: c = CNT_W'(P_INTEG_50HZ_CYC);
            default: c = CNT_W'(P_INTEG_60HZ_CYC);
        endcase
        if (fast && (c >> FAST_SH) != '0)
        begin
            c = c >> FAST_SH;
        end
        return c;
    endfunction

    function automatic int smooth_shift(acdf_smooth_t m);
        unique case (m)
            SMOOTH_NONE: return SMOOTH_SH_NONE;
            SMOOTH_WEAK: return SMOOTH_SH_WEAK;
            SMOOTH_MEDIUM: return SMOOTH_SH_MEDIUM;
            default: return SMOOTH_SH_STRONG;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // smoothing datapath
    acdf_filt_mem u_mem (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .wr_en_i(s_ff.st == ST_UPD),
        .wr_addr_i(s_ff.chan),
        .wr_data_i(acc_new),
        .rd_addr_i(s_ff.chan),
        .rd_data_o(rd_acc)
    );

    // recursive mean: y += (x - y) / N reaches 63 percent of a step after N cycles
    assign diff = $signed({s_ff.sample[DW-1], s_ff.sample, {FRAC{1'b0}}})
        - $signed({rd_acc[AW-1], rd_acc});
    assign step = diff >>> smooth_shift(smooth_i[s_ff.chan]);
    assign acc_new = rd_acc + step[AW-1:0];
    assign smooth_val = acc_new[AW-1:FRAC];

    assign chk_if.range = range_i[s_ff.chan];
    assign chk_if.raw = s_ff.sample;
    assign chk_if.value = smooth_val;
    assign chk_if.hi_lim = hi_limit_i[s_ff.chan];
    assign chk_if.lo_lim = lo_limit_i[s_ff.chan];

    acdf_chan_check u_chk (
        .chk(chk_if.chk)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // sequencer and diagnostics
    always_comb
    begin
        nxt_s = s_ff;
        nxt_s.valid = 1'b0;
        nxt_s.done = 1'b0;
        nxt_s.irq = 1'b0;
        nxt_s.enc = group_diag_en_i && enc_diag_en_i && enc_short_i;
        for (int c = 0; c < NCH; c++)
        begin
            nxt_s.sc_in[c] = sc_in_diag_en_i[c] && in_short_i[c]
                && (range_i[c] != RANGE_OFF);
            nxt_s.sc_out[c] = group_diag_en_i && sc_out_diag_en_i[c]
                && (out_short_p_i[c] || out_short_m_i[c]);
        end
        unique case (s_ff.st)
            ST_SCAN:
            begin
                if (range_i[s_ff.chan] != RANGE_OFF)
                begin
                    nxt_s.cnt = integ_cycles(freq_sel_i, fast_mode_i) - 1'b1;
                    nxt_s.cap_freq = freq_sel_i;
                    nxt_s.cap_fast = fast_mode_i;
                    nxt_s.gate_len = '0;
                    nxt_s.gate = 1'b1;
                    nxt_s.st = ST_INTEG;
                end
                else
                begin
                    // disabled channel: no integration slot at all
                    nxt_s.chan = s_ff.chan + 1'b1;
                    nxt_s.done = (s_ff.chan == CW'(NCH - 1));
                end
            end
            ST_INTEG:
            begin
                nxt_s.gate_len = s_ff.gate_len + 1'b1;
                if (s_ff.cnt == '0)
                begin
                    nxt_s.gate = 1'b0;
                    nxt_s.sample = sample_i;
                    nxt_s.st = ST_UPD;
                end
                else
                begin
                    nxt_s.cnt = s_ff.cnt - 1'b1;
                end
            end
            ST_UPD:
            begin
                if (chk_if.wire_break && wb_diag_en_i[s_ff.chan])
                begin
                    nxt_s.value[s_ff.chan] = VAL_WB_DIAG;
                end
                else if (chk_if.wire_break)
                begin
                    nxt_s.value[s_ff.chan] = VAL_WB_NODIAG;
                end
                else
                begin
                    nxt_s.value[s_ff.chan] = smooth_val;
                end
                nxt_s.wb[s_ff.chan] = chk_if.wire_break && wb_diag_en_i[s_ff.chan];
                nxt_s.ovf[s_ff.chan] = chk_if.overflow && ovf_diag_en_i[s_ff.chan];
                nxt_s.unf[s_ff.chan] = ovf_diag_en_i[s_ff.chan]
                    && (chk_if.underflow || chk_if.wire_break);
                nxt_s.hi_above[s_ff.chan] = chk_if.above_hi;
                nxt_s.lo_below[s_ff.chan] = chk_if.below_lo;
                if (limit_irq_en_i && chk_if.above_hi && !s_ff.hi_above[s_ff.chan])
                begin
                    nxt_s.irq = 1'b1;
                    nxt_s.irq_hi = 1'b1;
                    nxt_s.irq_chan = s_ff.chan;
                end
                else if (limit_irq_en_i && chk_if.below_lo && !s_ff.lo_below[s_ff.chan])
                begin
                    nxt_s.irq = 1'b1;
                    nxt_s.irq_hi = 1'b0;
                    nxt_s.irq_chan = s_ff.chan;
                end
                nxt_s.valid = 1'b1;
                nxt_s.val_chan = s_ff.chan;
                nxt_s.done = (s_ff.chan == CW'(NCH - 1));
                nxt_s.chan = s_ff.chan + 1'b1;
                nxt_s.st = ST_SCAN;
            end
        endcase
        if (!group_diag_en_i)
        begin
            nxt_s.wb = '0;
            nxt_s.ovf = '0;
            nxt_s.unf = '0;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            s_ff <= '0;
        end
        else
        begin
            s_ff <= nxt_s;
        end
    end

    assign conv_gate_o = s_ff.gate;
    assign conv_chan_o = s_ff.chan;
    assign value_o = s_ff.value;
    assign value_valid_o = s_ff.valid;
    assign value_chan_o = s_ff.val_chan;
    assign cycle_done_o = s_ff.done;
    assign diag_wb_o = s_ff.wb;
    assign diag_ovf_o = s_ff.ovf;
    assign diag_unf_o = s_ff.unf;
    assign diag_sc_in_o = s_ff.sc_in;
    assign diag_sc_out_o = s_ff.sc_out;
    assign diag_enc_o = s_ff.enc;
    assign limit_irq_o = s_ff.irq;
    assign limit_chan_o = s_ff.irq_chan;
    assign limit_hi_o = s_ff.irq_hi;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_b_i);

    AST_ENC_GATED: assert property (!group_diag_en_i |=> !diag_enc_o)
        else $error("encoder short reported with group diagnostics off");
    AST_SC_IN_FREE: assert property ((!group_diag_en_i && sc_in_diag_en_i[0] && in_short_i[0]
        && range_i[0] != RANGE_OFF) |=> diag_sc_in_o[0])
        else $error("input short lost while group diagnostics off");
    AST_GROUP_OFF: assert property (!group_diag_en_i |=> (diag_wb_o == '0
        && diag_ovf_o == '0 && diag_unf_o == '0))
        else $error("diagnostics reported with group diagnostics off");
    AST_INTEG_LEN: assert property ($fell(conv_gate_o)
        |-> s_ff.gate_len == integ_cycles(s_ff.cap_freq, s_ff.cap_fast))
        else $error("integration window length wrong");
    AST_FAST_SHORT: assert property (($fell(conv_gate_o) && s_ff.cap_fast)
        |-> s_ff.gate_len < integ_cycles(s_ff.cap_freq, 1'b0))
        else $error("fast mode not shorter than slow mode");
    AST_OFF_SKIP: assert property ($rose(conv_gate_o) |-> $past(range_i[conv_chan_o]) != RANGE_OFF)
        else $error("disabled channel integrated");
    AST_NO_SMOOTH: assert property ((s_ff.st == ST_UPD && smooth_i[s_ff.chan] == SMOOTH_NONE
        && !chk_if.wire_break) |=> value_o[value_chan_o] == s_ff.sample)
        else $error("unsmoothed value differs from sample");
    AST_WB_DIAG: assert property ((s_ff.st == ST_UPD && range_i[s_ff.chan] == RANGE_U_1_5
        && $signed(s_ff.sample) <= WB_U_MV && wb_diag_en_i[s_ff.chan])
        |=> value_o[value_chan_o] == VAL_WB_DIAG)
        else $error("wire break code not 7FFF");
    AST_WB_NODIAG: assert property ((s_ff.st == ST_UPD && range_i[s_ff.chan] == RANGE_I_4_20
        && $signed(s_ff.sample) <= WB_I_UA && !wb_diag_en_i[s_ff.chan])
        |=> value_o[value_chan_o] == VAL_WB_NODIAG)
        else $error("wire break code not 8000");
    AST_LIM_HI: assert property ((limit_irq_o && limit_hi_o) |-> $past(limit_irq_en_i)
        && $signed(value_o[limit_chan_o]) > $signed(hi_limit_i[limit_chan_o]))
        else $error("high limit interrupt without cause");
    AST_LIM_LO: assert property ((limit_irq_o && !limit_hi_o) |-> $past(limit_irq_en_i)
        && $signed(value_o[limit_chan_o]) < $signed(lo_limit_i[limit_chan_o]))
        else $error("low limit interrupt without cause");

    COV_CYCLE: cover property (cycle_done_o);
    COV_WB: cover property (value_valid_o && diag_wb_o != '0);
    COV_LIMIT: cover property (limit_irq_o && limit_hi_o);
endmodule

/* File: testbench.sv */
// Purpose: self-checking bench for the channel diag/filter block
// Assumes: shortened integration counts of 40/20/16 cycles
// Notes: channels 0 and 1 carry the traffic, 2 and 3 stay disabled
`timescale 1ns/1ps
module testbench;
    import acdf_pkg::*;
    logic clock_i = 0;
    logic rst_b_i = 0;
    logic group_diag_en_i = 1, enc_diag_en_i = 1, limit_irq_en_i = 1, fast_mode_i = 0;
    acdf_freq_t freq_sel_i = FREQ_50HZ;
    acdf_range_t [NCH-1:0] range_i;
    acdf_smooth_t [NCH-1:0] smooth_i;
    logic [NCH-1:0] wb_diag_en_i = '1, ovf_diag_en_i = '1, sc_in_diag_en_i = '1;
    logic [NCH-1:0] sc_out_diag_en_i = '1, in_short_i = '0, out_short_p_i = '0;
    logic [NCH-1:0] out_short_m_i = '0;
    logic enc_short_i = 0;
    logic [NCH-1:0][DW-1:0] hi_limit_i, lo_limit_i, lvl, value_o;
    logic [DW-1:0] sample_i;
    logic conv_gate_o, value_valid_o, cycle_done_o, diag_enc_o, limit_irq_o, limit_hi_o;
    logic [CW-1:0] conv_chan_o, value_chan_o, limit_chan_o;
    logic [NCH-1:0] diag_wb_o, diag_ovf_o, diag_unf_o, diag_sc_in_o, diag_sc_out_o;
    int error_cnt = 0, comparisons = 0, cyc = 0, n, done_cnt = 0;
    logic irq_seen;
    logic [CW-1:0] gch;
    int gexp [6] = '{40, 10, 20, 5, 16, 4};
    acdf_range_t wr [4] = '{RANGE_U_1_5, RANGE_U_1_5, RANGE_I_4_20, RANGE_I_4_20};
    logic [DW-1:0] wl [4] = '{16'h0128, 16'h0129, 16'h04A1, 16'h00C8};
    logic [DW-1:0] wv [4] = '{16'h7FFF, 16'h0129, 16'h7FFF, 16'h8000};
    logic ww [4] = '{1'b1, 1'b1, 1'b1, 1'b0};

    acdf_top #(.P_INTEG_10HZ_CYC(40), .P_INTEG_50HZ_CYC(20), .P_INTEG_60HZ_CYC(16)) DUT (
        .clock_i(clock_i), .rst_b_i(rst_b_i), .group_diag_en_i(group_diag_en_i),
        .enc_diag_en_i(enc_diag_en_i), .limit_irq_en_i(limit_irq_en_i),
        .fast_mode_i(fast_mode_i), .freq_sel_i(freq_sel_i), .range_i(range_i),
        .smooth_i(smooth_i), .wb_diag_en_i(wb_diag_en_i), .ovf_diag_en_i(ovf_diag_en_i),
        .sc_in_diag_en_i(sc_in_diag_en_i), .sc_out_diag_en_i(sc_out_diag_en_i),
        .hi_limit_i(hi_limit_i), .lo_limit_i(lo_limit_i), .sample_i(sample_i),
        .in_short_i(in_short_i), .out_short_p_i(out_short_p_i),
        .out_short_m_i(out_short_m_i), .enc_short_i(enc_short_i),
        .conv_gate_o(conv_gate_o), .conv_chan_o(conv_chan_o), .value_o(value_o),
        .value_valid_o(value_valid_o), .value_chan_o(value_chan_o),
        .cycle_done_o(cycle_done_o), .diag_wb_o(diag_wb_o), .diag_ovf_o(diag_ovf_o),
        .diag_unf_o(diag_unf_o), .diag_sc_in_o(diag_sc_in_o),
        .diag_sc_out_o(diag_sc_out_o), .diag_enc_o(diag_enc_o),
        .limit_irq_o(limit_irq_o), .limit_chan_o(limit_chan_o), .limit_hi_o(limit_hi_o));
    acdf_conv_model conv (.clock_i(clock_i), .gate_i(conv_gate_o), .chan_i(conv_chan_o),
        .level_i(lvl), .sample_o(sample_i));

    always #10 clock_i = ~clock_i;

    ////////////////////////////////////////////////////////////////////////////////
    // every settled cycle is looked at once, so one-cycle pulses are counted
    task automatic tick(input int k);
        repeat (k)
        begin
            @(posedge clock_i);
            #1;
            if (cycle_done_o === 1'b1)
                done_cnt++;
        end
    endtask
    task automatic chk_val(input string nm, input logic [DW-1:0] e, input logic [DW-1:0] g);
        comparisons++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_bit(input string nm, input logic e, input logic g);
        chk_val(nm, {15'h0000, e}, {15'h0000, g});
    endtask
    // waits for the update of one channel and notes a limit pulse beside it
    task automatic wait_val(input logic [CW-1:0] ch);
        int k;
        for (k = 0; k < 3000; k++)
        begin
            tick(1);
            if (value_valid_o === 1'b1 && value_chan_o === ch)
            begin
                irq_seen = limit_irq_o;
                return;
            end
        end
        chk_bit("value_valid", 1'b1, 1'b0);
    endtask
    task automatic gate_len(output int w, output logic [CW-1:0] ch);
        int k;
        w = 0;
        for (k = 0; k < 500 && conv_gate_o !== 1'b1; k++) tick(1);
        ch = conv_chan_o;
        while (conv_gate_o === 1'b1 && w < 500)
        begin
            tick(1);
            w++;
        end
    endtask
    task automatic do_reset();
        rst_b_i = 0;
        tick(2);
        rst_b_i = 1;
    endtask
    task automatic print_verdict();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge clock_i)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            error_cnt++;
            print_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        for (int i = 0; i < NCH; i++)
        begin
            range_i[i] = (i == 0) ? RANGE_U_PM10 : RANGE_OFF;
            smooth_i[i] = SMOOTH_NONE;
        end
        hi_limit_i = {4{16'h7000}};
        lo_limit_i = {4{16'h8000}};
        lvl = '0;
        do_reset();
        for (int i = 0; i < 6; i++)
        begin
            freq_sel_i = acdf_freq_t'(i / 2);
            fast_mode_i = 1'(i % 2);
            gate_len(n, gch);
            gate_len(n, gch);
            chk_val("gate_len", 16'(gexp[i]), 16'(n));
            chk_val("conv_chan", 16'h0000, 16'(gch));
        end
        freq_sel_i = FREQ_50HZ;
        fast_mode_i = 0;
        lvl[0] = 16'h03E8;
        wait_val(0);
        wait_val(0);
        chk_val("value0", 16'h03E8, value_o[0]);
        n = done_cnt;
        hi_limit_i[0] = 16'h01F4;
        wait_val(0);
        chk_val("cycle_done", 16'h0001, 16'(done_cnt - n));
        chk_bit("irq_hi", 1'b1, irq_seen);
        chk_bit("limit_hi", 1'b1, limit_hi_o);
        chk_val("limit_chan", 16'h0000, 16'(limit_chan_o));
        wait_val(0);
        chk_bit("irq_repeat", 1'b0, irq_seen);
        hi_limit_i[0] = 16'h7000;
        lo_limit_i[0] = 16'h07D0;
        wait_val(0);
        chk_bit("irq_lo", 1'b1, irq_seen);
        chk_bit("limit_lo", 1'b0, limit_hi_o);
        lvl[0] = 16'h2EE0;
        wait_val(0);
        wait_val(0);
        chk_bit("diag_ovf", 1'b1, diag_ovf_o[0]);
        lvl[0] = 16'hD120;
        wait_val(0);
        wait_val(0);
        chk_bit("diag_unf", 1'b1, diag_unf_o[0]);
        for (int i = 0; i < 4; i++)
        begin
            range_i[1] = wr[i];
            lvl[1] = wl[i];
            wb_diag_en_i[1] = ww[i];
            wait_val(1);
            wait_val(1);
            chk_val("value1", wv[i], value_o[1]);
            chk_bit("diag_wb", wv[i] == 16'h7FFF, diag_wb_o[1]);
        end
        chk_bit("diag_unf_wb", 1'b1, diag_unf_o[1]);
        group_diag_en_i = 0;
        in_short_i[0] = 1;
        out_short_p_i[0] = 1;
        enc_short_i = 1;
        tick(3);
        chk_bit("sc_in", 1'b1, diag_sc_in_o[0]);
        chk_bit("sc_out_off", 1'b0, diag_sc_out_o[0]);
        chk_bit("enc_off", 1'b0, diag_enc_o);
        group_diag_en_i = 1;
        tick(3);
        chk_bit("sc_out", 1'b1, diag_sc_out_o[0]);
        chk_bit("enc", 1'b1, diag_enc_o);
        out_short_p_i[0] = 0;
        out_short_m_i[0] = 1;
        enc_diag_en_i = 0;
        tick(3);
        chk_bit("enc_masked", 1'b0, diag_enc_o);
        chk_bit("sc_out_m", 1'b1, diag_sc_out_o[0]);
        range_i[1] = RANGE_OFF;
        lo_limit_i[0] = 16'h8000;
        for (int s = 1; s < 4; s++)
        begin
            smooth_i[0] = acdf_smooth_t'(s);
            lvl[0] = 16'h0000;
            rst_b_i = 0;
            tick(2);
            lvl[0] = 16'h03E8;
            rst_b_i = 1;
            repeat ((s == 1 ? 4 : (s == 2 ? 16 : 32)) - 1) wait_val(0);
            chk_bit("below63", 1'b1, $signed(value_o[0]) < 16'sh0276);
            wait_val(0);
            chk_bit("reach63", 1'b1, $signed(value_o[0]) >= 16'sh0276);
        end
        print_verdict();
    end
endmodule
